// >>> pmc_pkg.sv
// package for the power-mode controller: modes, power-domain bundle and timing constants
package pmc_pkg;
	// power modes, also the state encoding of the controller
	typedef enum logic [2:0] {
		PM_ACTIVE,
		PM_MODEM_SLEEP,
		PM_LIGHT_SLEEP,
		PM_DEEP_SLEEP,
		PM_HIBERNATE
	} pmc_mode_e;
	// sleep pattern selection
	typedef enum logic [1:0] {
		PAT_NONE,
		PAT_ASSOC,
		PAT_SENSOR
	} pmc_pattern_e;
	// cpu clock speed setting while in modem-sleep
	typedef enum logic [1:0] {
		CPU_MAX,
		CPU_NORMAL,
		CPU_SLOW
	} pmc_speed_e;
	// one enable per power or clock domain
	typedef struct packed {
		logic cpuRun;
		logic radioOn;
		logic basebandOn;
		logic aonMemOn;
		logic aonPeriphOn;
		logic recoveryMemOn;
		logic coprocOn;
		logic fastOscOn;
		logic slowTimerOn;
		logic aonPinsOn;
		logic serialPeriphOn;
	} pmc_domains_s;
	// wake sources
	typedef struct packed {
		logic mac;
		logic host;
		logic aonTimer;
		logic extIrq;
		logic coproc;
		logic aonPin;
	} pmc_wake_s;
	// cpu clock frequencies in MHz, published with the speed setting
	localparam logic [7:0] CPU_MAX_MHZ = 8'hf0;
	localparam logic [7:0] CPU_NORMAL_MHZ = 8'h50;
	localparam logic [7:0] CPU_SLOW_MHZ = 8'h02;
	// load thresholds in percent that pick the speed
	localparam logic [6:0] LOAD_HIGH = 7'h46;
	localparam logic [6:0] LOAD_LOW = 7'h0a;
	// converter duty: on for ADC_ON_CNT out of ADC_PERIOD_CNT slow ticks (1 %)
	localparam logic [6:0] ADC_PERIOD_CNT = 7'h64;
	localparam logic [6:0] ADC_ON_CNT = 7'h01;
	// clock rate and the slow tick period
	localparam int MCLK_HZ = 20000000;
	localparam int SLOW_TICK_NS = 1000;
	localparam int SLOW_TICK_CYC = (SLOW_TICK_NS * (MCLK_HZ / 1000000)) / 1000;
	// association pattern timing in slow ticks
	localparam logic [15:0] ASSOC_SLEEP_TICKS = 16'h0064;
	localparam logic [15:0] ASSOC_AWAKE_TICKS = 16'h000a;
endpackage

// >>> pmc_power_mode_controller.sv
// power-mode controller: domain enables, sleep entry, wake-up and sleep patterns
// How it works
// - active powers radio, cpu, always-on, coprocessor
// - modem-sleep runs cpu, radio and baseband off
// - light-sleep pauses cpu, always-on keeps running
// - mac, host, timer or irq wake resumes from light-sleep
// - deep-sleep keeps always-on memory, peripherals, recovery memory, slow timer, pins
// - hibernate: fast osc, coprocessor, recovery memory off
// - hibernate exits on timer or enabled pin
// - association pattern steps modem, light, then active
// - sensor pattern: cpu deep-sleeps, coprocessor wakes
// - converter runs at one percent duty
// - lan enabled toggles active and modem-sleep
// - modem-sleep cpu speed follows load
// - deep-sleep with coprocessor keeps pins, serial
`timescale 1ns/1ps
module pmc_power_mode_controller #(
	parameter int TICK_CYC = pmc_pkg::SLOW_TICK_CYC,
	parameter int AON_PINS = 4
) (
	input wire logic mclk,
	input wire logic rst_n,
	input wire logic powerUpPin,
	input wire logic modeReqValid,
	input wire pmc_pkg::pmc_mode_e modeReq,
	input wire pmc_pkg::pmc_pattern_e patternSel,
	input wire logic lanEnable,
	input wire logic lanTraffic,
	input wire logic [6:0] cpuLoad,
	input wire logic periphFastNeed,
	input wire logic coprocEnable,
	input wire logic [15:0] hibTimerTicks,
	input wire pmc_pkg::pmc_wake_s wakeIn,
	input wire logic [AON_PINS-1:0] aonPinWake,
	input wire logic [AON_PINS-1:0] aonPinEnable,
	output pmc_pkg::pmc_domains_s domains,
	output pmc_pkg::pmc_mode_e currentMode,
	output pmc_pkg::pmc_speed_e cpuSpeed,
	output logic [7:0] cpuMhz,
	output logic adcEnable,
	output logic chipPoweredOff
);
	// three-stage synchronisers for pin inputs
	logic [2:0] puSync;
	logic [AON_PINS-1:0] pinS1;
	logic [AON_PINS-1:0] pinS2;
	logic [AON_PINS-1:0] pinS3;
	logic puStable;
	logic [AON_PINS-1:0] pinStable;
	logic [AON_PINS-1:0] next_pinStable;
	logic next_puStable;
	// slow tick divider
	logic [15:0] divCnt;
	logic [15:0] next_divCnt;
	logic tick;
	// mode state and counters
	pmc_pkg::pmc_mode_e mode;
	pmc_pkg::pmc_mode_e next_mode;
	logic [15:0] timer;
	logic [15:0] next_timer;
	logic [6:0] adcCnt;
	logic [6:0] next_adcCnt;
	logic offState;
	logic next_offState;
	pmc_pkg::pmc_speed_e next_cpuSpeed;
	pmc_pkg::pmc_domains_s next_domains;
	logic [7:0] next_cpuMhz;
	logic next_adcEnable;
	logic anyWake;
	logic pinWake;

	// synchroniser chain; first stage read only by the second
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			puSync <= 3'h0;
			pinS1 <= '0;
			pinS2 <= '0;
			pinS3 <= '0;
			puStable <= 1'b0;
			pinStable <= '0;
		end else begin
			puSync <= {puSync[1:0], powerUpPin};
			pinS1 <= aonPinWake;
			pinS2 <= pinS1;
			pinS3 <= pinS2;
			puStable <= next_puStable;
			pinStable <= next_pinStable;
		end
	end

	// a level change counts once stages two and three agree
	always_comb begin
		next_puStable = puStable;
		if (puSync[1] == puSync[2]) begin
			next_puStable = puSync[2];
		end
		next_pinStable = (pinS2 & pinS3) | (pinStable & (pinS2 | pinS3));
	end

	// slow tick: one-cycle enable from a divider
	always_comb begin
		tick = (divCnt == 16'(TICK_CYC - 1));
		next_divCnt = tick ? 16'h0000 : divCnt + 16'h0001;
	end

	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			divCnt <= 16'h0000;
		end else begin
			divCnt <= next_divCnt;
		end
	end

	// wake conditions; only enabled always-on pins count
	always_comb begin
		pinWake = |(pinStable & aonPinEnable);
		anyWake = wakeIn.mac | wakeIn.host | wakeIn.aonTimer | wakeIn.extIrq;
	end

	// mode sequencer
	always_comb begin
		next_mode = mode;
		next_timer = timer;
		next_offState = !puStable;
		if (tick && timer != 16'h0000) begin
			next_timer = timer - 16'h0001;
		end
		case (mode)
			pmc_pkg::PM_ACTIVE: begin
				if (modeReqValid && modeReq != pmc_pkg::PM_ACTIVE) begin
					// sleep entry by software request, or modem-sleep when the lan idles
					next_mode = modeReq;
					next_timer = (modeReq == pmc_pkg::PM_HIBERNATE) ? hibTimerTicks : pmc_pkg::ASSOC_SLEEP_TICKS;
				end else if (lanEnable && !lanTraffic) begin
					// idle lan link drops the radio
					next_mode = pmc_pkg::PM_MODEM_SLEEP;
				end
			end
			pmc_pkg::PM_MODEM_SLEEP: begin
				if (modeReqValid && modeReq != pmc_pkg::PM_MODEM_SLEEP) begin
					next_mode = modeReq;
					next_timer = (modeReq == pmc_pkg::PM_HIBERNATE) ? hibTimerTicks : pmc_pkg::ASSOC_SLEEP_TICKS;
				end else if (lanEnable && lanTraffic) begin
					next_mode = pmc_pkg::PM_ACTIVE;
				end else if (patternSel == pmc_pkg::PAT_ASSOC && !lanEnable) begin
					// between beacons drop to light-sleep
					next_mode = pmc_pkg::PM_LIGHT_SLEEP;
					next_timer = pmc_pkg::ASSOC_SLEEP_TICKS;
				end
			end
			pmc_pkg::PM_LIGHT_SLEEP: begin
				if (anyWake) begin
					next_mode = pmc_pkg::PM_ACTIVE;
				end else if (patternSel == pmc_pkg::PAT_ASSOC && timer == 16'h0000) begin
					// predetermined interval: wake cpu and radio
					next_mode = pmc_pkg::PM_ACTIVE;
					next_timer = pmc_pkg::ASSOC_AWAKE_TICKS;
				end
			end
			pmc_pkg::PM_DEEP_SLEEP: begin
				// in the sensor pattern only the coprocessor wakes the system
				if (wakeIn.coproc && coprocEnable) begin
					next_mode = pmc_pkg::PM_ACTIVE;
				end else if (patternSel != pmc_pkg::PAT_SENSOR && (wakeIn.aonTimer || pinWake)) begin
					next_mode = pmc_pkg::PM_ACTIVE;
				end
			end
			pmc_pkg::PM_HIBERNATE: begin
				if ((tick && timer == 16'h0001) || pinWake) begin
					next_mode = pmc_pkg::PM_ACTIVE;
				end
			end
			default: begin
				next_mode = pmc_pkg::PM_ACTIVE;
			end
		endcase
		if (!puStable) begin
			// powered off: restart in active once the pin rises
			next_mode = pmc_pkg::PM_ACTIVE;
		end
	end

	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			mode <= pmc_pkg::PM_ACTIVE;
			timer <= 16'h0000;
			offState <= 1'b1;
		end else begin
			mode <= next_mode;
			timer <= next_timer;
			offState <= next_offState;
		end
	end

	// domain enables and speed from the next mode, registered below
	always_comb begin
		next_domains = '0;
		next_cpuSpeed = pmc_pkg::CPU_MAX;
		next_cpuMhz = pmc_pkg::CPU_MAX_MHZ;
		case (next_mode)
			pmc_pkg::PM_ACTIVE: begin
				next_domains = '1;
			end
			pmc_pkg::PM_MODEM_SLEEP: begin
				next_domains = '1;
				next_domains.radioOn = 1'b0;
				next_domains.basebandOn = 1'b0;
				// speed follows load; fast peripherals keep normal at least
				if (cpuLoad >= pmc_pkg::LOAD_HIGH) begin
					next_cpuSpeed = pmc_pkg::CPU_MAX;
					next_cpuMhz = pmc_pkg::CPU_MAX_MHZ;
				end else if (cpuLoad > pmc_pkg::LOAD_LOW || periphFastNeed) begin
					next_cpuSpeed = pmc_pkg::CPU_NORMAL;
					next_cpuMhz = pmc_pkg::CPU_NORMAL_MHZ;
				end else begin
					next_cpuSpeed = pmc_pkg::CPU_SLOW;
					next_cpuMhz = pmc_pkg::CPU_SLOW_MHZ;
				end
			end
			pmc_pkg::PM_LIGHT_SLEEP: begin
				next_domains = '1;
				next_domains.cpuRun = 1'b0;
				next_domains.radioOn = 1'b0;
				next_domains.basebandOn = 1'b0;
			end
			pmc_pkg::PM_DEEP_SLEEP: begin
				// link state survives in always-on memory
				next_domains.aonMemOn = 1'b1;
				next_domains.aonPeriphOn = 1'b1;
				next_domains.recoveryMemOn = 1'b1;
				next_domains.slowTimerOn = 1'b1;
				next_domains.aonPinsOn = 1'b1;
				next_domains.coprocOn = coprocEnable;
				next_domains.serialPeriphOn = coprocEnable;
			end
			pmc_pkg::PM_HIBERNATE: begin
				// fast osc, coprocessor, recovery memory stay off
				next_domains.slowTimerOn = 1'b1;
				next_domains.aonPinsOn = 1'b1;
			end
			default: begin
				next_domains = '0;
			end
		endcase
		if (!puStable) begin
			next_domains = '0;
			next_cpuMhz = 8'h00;
		end
		if (next_domains.cpuRun == 1'b0) begin
			next_cpuMhz = 8'h00;
		end
	end

	// converter duty counter, one on-tick every hundred
	always_comb begin
		next_adcCnt = adcCnt;
		next_adcEnable = 1'b0;
		if (mode == pmc_pkg::PM_DEEP_SLEEP && patternSel == pmc_pkg::PAT_SENSOR && coprocEnable) begin
			if (tick) begin
				next_adcCnt = (adcCnt == pmc_pkg::ADC_PERIOD_CNT - 7'h01) ? 7'h00 : adcCnt + 7'h01;
			end
			next_adcEnable = (next_adcCnt < pmc_pkg::ADC_ON_CNT);
		end else begin
			next_adcCnt = 7'h00;
		end
	end

	// outputs registered
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			domains <= '0;
			cpuSpeed <= pmc_pkg::CPU_MAX;
			cpuMhz <= 8'h00;
			adcCnt <= 7'h00;
			adcEnable <= 1'b0;
		end else begin
			domains <= next_domains;
			cpuSpeed <= next_cpuSpeed;
			cpuMhz <= next_cpuMhz;
			adcCnt <= next_adcCnt;
			adcEnable <= next_adcEnable;
		end
	end

	// mode reported for software confirmation
	assign currentMode = mode;
	assign chipPoweredOff = offState;

	// checks
	sequence s_lightWake;
		mode == pmc_pkg::PM_LIGHT_SLEEP && anyWake && puStable;
	endsequence
	property p_lightWake;
		@(posedge mclk) disable iff (!rst_n) s_lightWake |=> mode == pmc_pkg::PM_ACTIVE ##1 domains.radioOn;
	endproperty
	a_lightWake: assert property (p_lightWake) else $error("light-sleep wake not honoured");
	property p_activeAll;
		@(posedge mclk) disable iff (!rst_n) mode == pmc_pkg::PM_ACTIVE && $past(puStable) |-> domains == '1;
	endproperty
	a_activeAll: assert property (p_activeAll) else $error("active domains not all on");
	property p_modemRadio;
		@(posedge mclk) disable iff (!rst_n) $past(next_mode) == pmc_pkg::PM_MODEM_SLEEP && mode == pmc_pkg::PM_MODEM_SLEEP
			&& $past(puStable) |-> !domains.radioOn && domains.cpuRun;
	endproperty
	a_modemRadio: assert property (p_modemRadio) else $error("modem-sleep domains wrong");
	property p_lightCpu;
		@(posedge mclk) disable iff (!rst_n) $past(next_mode) == pmc_pkg::PM_LIGHT_SLEEP && $past(puStable)
			|-> !domains.cpuRun && domains.aonMemOn && domains.coprocOn;
	endproperty
	a_lightCpu: assert property (p_lightCpu) else $error("light-sleep domains wrong");
	property p_deep;
		@(posedge mclk) disable iff (!rst_n) $past(next_mode) == pmc_pkg::PM_DEEP_SLEEP && $past(puStable)
			|-> !domains.cpuRun && domains.aonMemOn && domains.serialPeriphOn == $past(coprocEnable);
	endproperty
	a_deep: assert property (p_deep) else $error("deep-sleep domains wrong");
	property p_hib;
		@(posedge mclk) disable iff (!rst_n) $past(next_mode) == pmc_pkg::PM_HIBERNATE
			|-> !domains.fastOscOn && !domains.coprocOn && !domains.recoveryMemOn;
	endproperty
	a_hib: assert property (p_hib) else $error("hibernate left domains on");
	property p_hibStay;
		@(posedge mclk) disable iff (!rst_n) mode == pmc_pkg::PM_HIBERNATE && !pinWake && !tick && puStable
			|=> mode == pmc_pkg::PM_HIBERNATE;
	endproperty
	a_hibStay: assert property (p_hibStay) else $error("hibernate left without cause");
	property p_noReqSleep;
		@(posedge mclk) disable iff (!rst_n) mode == pmc_pkg::PM_ACTIVE && !modeReqValid && !lanEnable
			|=> mode == pmc_pkg::PM_ACTIVE;
	endproperty
	a_noReqSleep: assert property (p_noReqSleep) else $error("sleep entered without request");
	property p_off;
		@(posedge mclk) disable iff (!rst_n) !puStable |=> domains == '0 && chipPoweredOff;
	endproperty
	a_off: assert property (p_off) else $error("power-off not applied");
endmodule

// >>> pmc_power_mode_controller_tb_top.sv
// self-checking bench for the power-mode controller
`timescale 1ns/1ps
`define CHK(nm, e, g) begin numChecks++; if ((g) !== (e)) begin failCount++; \
	$display("wrong value %s exp %0h got %0h", nm, e, g); end end
module pmc_power_mode_controller_tb_top;
	logic mclk = 0; // 20 MHz system clock
	logic rst_n = 0; // sync reset, active low
	logic powerUpPin = 1; // chip powered while high
	logic modeReqValid = 0;
	logic lanEnable = 0;
	logic lanTraffic = 0;
	logic periphFastNeed = 0;
	logic coprocEnable = 0;
	logic started = 0; // monitor armed after reset
	pmc_pkg::pmc_mode_e modeReq = pmc_pkg::PM_ACTIVE;
	pmc_pkg::pmc_mode_e currentMode, prevMode, eMode;
	pmc_pkg::pmc_pattern_e patternSel = pmc_pkg::PAT_NONE;
	logic [6:0] cpuLoad = 7'h00;
	logic [15:0] hibTimerTicks = 16'h0014;
	pmc_pkg::pmc_wake_s wakeIn = '0;
	logic [3:0] aonPinWake = 4'h0;
	logic [3:0] aonPinEnable = 4'h0;
	pmc_pkg::pmc_domains_s domains;
	pmc_pkg::pmc_speed_e cpuSpeed;
	logic [7:0] cpuMhz;
	logic [7:0] rnd = 8'h19; // lfsr state, seed 25
	logic adcEnable, chipPoweredOff;
	logic [21:0] dExp; // {mask, value} of domain bits
	int failCount = 0;
	int numChecks = 0;
	pmc_pkg::pmc_mode_e expQ[$]; // expected mode changes in order
	// short tick keeps the pattern timers brief
	pmc_power_mode_controller #(.TICK_CYC(2), .AON_PINS(4)) u_pmc_power_mode_controller (
		.mclk(mclk), .rst_n(rst_n), .powerUpPin(powerUpPin), .modeReqValid(modeReqValid),
		.modeReq(modeReq), .patternSel(patternSel), .lanEnable(lanEnable), .lanTraffic(lanTraffic),
		.cpuLoad(cpuLoad), .periphFastNeed(periphFastNeed), .coprocEnable(coprocEnable),
		.hibTimerTicks(hibTimerTicks), .wakeIn(wakeIn), .aonPinWake(aonPinWake),
		.aonPinEnable(aonPinEnable), .domains(domains), .currentMode(currentMode), .cpuSpeed(cpuSpeed),
		.cpuMhz(cpuMhz), .adcEnable(adcEnable), .chipPoweredOff(chipPoweredOff));
	// clock generator
	initial begin
		forever #25 mclk = ~mclk;
	end
	// next pseudo-random byte
	function automatic logic [7:0] lfsr(input logic [7:0] s);
		return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
	endfunction
	// domain bits that each mode fixes; the rest are left free
	function automatic logic [21:0] domExp(input pmc_pkg::pmc_mode_e m);
		case (m)
			pmc_pkg::PM_ACTIVE: return {11'h7d0, 11'h7d0};
			pmc_pkg::PM_MODEM_SLEEP: return {11'h700, 11'h400};
			pmc_pkg::PM_LIGHT_SLEEP: return {11'h4d0, 11'h0d0};
			pmc_pkg::PM_DEEP_SLEEP: return {11'h7c0, 11'h0c0};
			default: return {11'h43e, 11'h006};
		endcase
	endfunction
	// verdict, the single end of the run
	task automatic finishTest();
		$display("checks %0d errors %0d", numChecks, failCount);
		if (failCount == 0 && numChecks > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	// wait, bounded, for the mode to arrive
	task automatic waitMode(input pmc_pkg::pmc_mode_e m, input int n);
		int i;
		for (i = 0; i < n && currentMode !== m; i++) @(negedge mclk);
		if (currentMode !== m) begin
			failCount++;
			$display("wrong value waitMode exp %0h got %0h", m, currentMode);
		end
	endtask
	// software mode request, one cycle pulse
	task automatic req(input pmc_pkg::pmc_mode_e m);
		expQ.push_back(m);
		@(posedge mclk);
		modeReqValid <= 1;
		modeReq <= m;
		@(posedge mclk);
		modeReqValid <= 0;
		waitMode(m, 8);
	endtask
	// pick the oldest note on every mode change; an unnoted change is an error
	always @(negedge mclk) begin
		if (started && currentMode !== prevMode) begin
			if (expQ.size() == 0) `CHK("unexpected mode", prevMode, currentMode)
			else begin
				eMode = expQ.pop_front();
				dExp = domExp(eMode);
				`CHK("mode", eMode, currentMode)
				`CHK("domains", dExp[10:0], domains & dExp[21:11])
			end
			prevMode = currentMode;
		end
	end
	// hang guard, far above the few thousand cycles the tests need
	initial begin
		repeat (30000) @(posedge mclk);
		failCount++;
		$display("wrong value watchdog exp done got hang");
		finishTest();
	end
	// main sequence
	initial begin
		logic [6:0] tbl[4];
		logic [6:0] ld;
		int i;
		int adcCnt;
		tbl = '{7'h46, 7'h45, 7'h0b, 7'h0a}; // load boundaries
		repeat (5) @(posedge mclk);
		rst_n <= 1;
		repeat (8) @(negedge mclk);
		prevMode = currentMode;
		started = 1;
		`CHK("reset mode", pmc_pkg::PM_ACTIVE, currentMode)
		`CHK("active domains", 11'h7d0, domains & 11'h7d0)
		// light sleep, woken by mac, host, timer and irq events in turn
		for (i = 0; i < 4; i++) begin
			req(pmc_pkg::PM_LIGHT_SLEEP);
			`CHK("paused mhz", 8'h00, cpuMhz)
			// a request while asleep must be ignored
			@(posedge mclk);
			modeReqValid <= 1;
			modeReq <= pmc_pkg::PM_DEEP_SLEEP;
			@(posedge mclk);
			modeReqValid <= 0;
			repeat (4) @(posedge mclk);
			expQ.push_back(pmc_pkg::PM_ACTIVE);
			wakeIn <= 6'h20 >> i;
			waitMode(pmc_pkg::PM_ACTIVE, 8);
			@(posedge mclk);
			wakeIn <= '0;
		end
		// modem sleep speed against load, boundaries then random
		req(pmc_pkg::PM_MODEM_SLEEP);
		for (i = 0; i < 9; i++) begin
			rnd = lfsr(rnd);
			ld = (i < 4) ? tbl[i] : ((i == 8) ? 7'h05 : 7'(rnd % 8'd101));
			@(posedge mclk);
			cpuLoad <= ld;
			periphFastNeed <= (i == 8);
			repeat (3) @(negedge mclk);
			if (ld >= 7'h46) begin
				`CHK("cpuMhz", pmc_pkg::CPU_MAX_MHZ, cpuMhz)
				`CHK("cpuSpeed", pmc_pkg::CPU_MAX, cpuSpeed)
			end else if (ld > 7'h0a || i == 8) begin
				`CHK("cpuMhz", pmc_pkg::CPU_NORMAL_MHZ, cpuMhz)
				`CHK("cpuSpeed", pmc_pkg::CPU_NORMAL, cpuSpeed)
			end else begin
				`CHK("cpuMhz", pmc_pkg::CPU_SLOW_MHZ, cpuMhz)
				`CHK("cpuSpeed", pmc_pkg::CPU_SLOW, cpuSpeed)
			end
		end
		@(posedge mclk);
		periphFastNeed <= 0;
		req(pmc_pkg::PM_ACTIVE);
		// sensor pattern in deep sleep: timer must not wake, coprocessor does
		@(posedge mclk);
		coprocEnable <= 1;
		patternSel <= pmc_pkg::PAT_SENSOR;
		req(pmc_pkg::PM_DEEP_SLEEP);
		`CHK("deep periph", 3'h7, {domains.coprocOn, domains.aonPinsOn, domains.serialPeriphOn})
		@(posedge mclk);
		wakeIn <= 6'h08;
		adcCnt = 0;
		// ten converter periods of 200 cycles, on 2 cycles each
		repeat (2000) begin
			@(negedge mclk);
			if (adcEnable === 1'b1) adcCnt++;
		end
		`CHK("adc duty", 1'b1, adcCnt >= 18 && adcCnt <= 22)
		expQ.push_back(pmc_pkg::PM_ACTIVE);
		@(posedge mclk);
		wakeIn <= 6'h02;
		waitMode(pmc_pkg::PM_ACTIVE, 8);
		@(posedge mclk);
		wakeIn <= '0;
		patternSel <= pmc_pkg::PAT_NONE;
		repeat (3) @(negedge mclk);
		`CHK("adc off", 1'b0, adcEnable)
		// deep sleep outside the sensor pattern: coprocessor off, timer event wakes
		@(posedge mclk);
		coprocEnable <= 0;
		req(pmc_pkg::PM_DEEP_SLEEP);
		`CHK("deep coproc off", 2'h0, {domains.coprocOn, domains.serialPeriphOn})
		`CHK("adc idle", 1'b0, adcEnable)
		expQ.push_back(pmc_pkg::PM_ACTIVE);
		@(posedge mclk);
		wakeIn <= 6'h08;
		waitMode(pmc_pkg::PM_ACTIVE, 8);
		@(posedge mclk);
		wakeIn <= '0;
		// hibernate: host event ignored, timer of 20 ticks wakes
		req(pmc_pkg::PM_HIBERNATE);
		@(posedge mclk);
		wakeIn <= 6'h10;
		repeat (10) @(posedge mclk);
		wakeIn <= '0;
		expQ.push_back(pmc_pkg::PM_ACTIVE);
		waitMode(pmc_pkg::PM_ACTIVE, 60);
		// hibernate: disabled pin ignored, enabled pin wakes
		@(posedge mclk);
		hibTimerTicks <= 16'hffff;
		req(pmc_pkg::PM_HIBERNATE);
		@(posedge mclk);
		aonPinWake <= 4'h2;
		repeat (10) @(posedge mclk);
		expQ.push_back(pmc_pkg::PM_ACTIVE);
		aonPinEnable <= 4'h2;
		waitMode(pmc_pkg::PM_ACTIVE, 12);
		@(posedge mclk);
		aonPinWake <= 4'h0;
		// lan on: idle drops to modem sleep, traffic returns to active
		expQ.push_back(pmc_pkg::PM_MODEM_SLEEP);
		lanEnable <= 1;
		waitMode(pmc_pkg::PM_MODEM_SLEEP, 10);
		expQ.push_back(pmc_pkg::PM_ACTIVE);
		@(posedge mclk);
		lanTraffic <= 1;
		waitMode(pmc_pkg::PM_ACTIVE, 10);
		@(posedge mclk);
		lanEnable <= 0;
		lanTraffic <= 0;
		// association pattern: modem, light, then awake again
		patternSel <= pmc_pkg::PAT_ASSOC;
		req(pmc_pkg::PM_MODEM_SLEEP);
		expQ.push_back(pmc_pkg::PM_LIGHT_SLEEP);
		expQ.push_back(pmc_pkg::PM_ACTIVE);
		waitMode(pmc_pkg::PM_LIGHT_SLEEP, 250);
		waitMode(pmc_pkg::PM_ACTIVE, 250);
		@(posedge mclk);
		patternSel <= pmc_pkg::PAT_NONE;
		// power-up pin low turns everything off
		powerUpPin <= 0;
		repeat (8) @(negedge mclk);
		`CHK("off flag", 1'b1, chipPoweredOff)
		`CHK("off domains", 11'h000, domains)
		@(posedge mclk);
		powerUpPin <= 1;
		repeat (8) @(negedge mclk);
		`CHK("on flag", 1'b0, chipPoweredOff)
		`CHK("on domains", 11'h7d0, domains & 11'h7d0)
		`CHK("queue empty", 0, expQ.size())
		finishTest();
	end
endmodule
